// ===== include/pin_io_regs.svh
// Purpose: offsets, field positions, reset values for the pin io block
// Assumes: avalon-mm byte addressing, 32-bit data
// Notes: offsets are byte addresses
// Contract
// (RL1) status, done and error indicators are driven low to assert
// (RL2) boot select high at reset selects firmware download mode
// (RL3) boot select low at reset selects running the loaded firmware
// (RL4) a low key input is taken as a key interrupt event; the code sets it only on the high-to-low change
// (RL5) first build: one shared direction bit for all eight pins
// (RL6) first build: shared direction input makes all eight pins inputs
// (RL7) first build: shared direction output makes all eight pins outputs
// (RL8) an input pin driven low reads as an asserted data bit
// (RL9) an output pin asserts by driving low
// (RL10) second build: bits 7..4 fixed outputs, bits 3..0 fixed inputs
// (RL11) boot select is sampled once on leaving reset and held
`ifndef PIN_IO_REGS_SVH
`define PIN_IO_REGS_SVH
`define CTRL_OFS 5'h00
`define GPIO_OUT_OFS 5'h04
`define GPIO_IN_OFS 5'h08
`define STATUS_OFS 5'h0c
`define IRQ_STAT_OFS 5'h10
`define IRQ_CLR_OFS 5'h14
`define IRQ_EN_OFS 5'h18
`define CTRL_DIR_BIT 0
`define CTRL_BUILD_BIT 1
`define CTRL_IND_LO 4
`define ST_DOWNLOAD_BIT 0
`define IRQ_KEY_BIT 0
`define IRQ_GPIN_BIT 1
`define CTRL_RESET 32'h0000_0000
`define FIXED_OUT_MASK 8'hf0
`endif

// ===== include/pin_io_pkg.sv
// Purpose: types for the pin io block
// Assumes: nothing
// Notes: indicator bundle is active high inside, inverted at the pins
package pin_io_pkg;
    typedef struct packed {
        logic status;
        logic done;
        logic error;
    } ind_type;
    typedef enum logic [1:0] {
        boot_wait_type = 2'b00,
        boot_run_type = 2'b01,
        boot_dl_type = 2'b10
    } boot_type;
endpackage

// ===== logic/pin_io.sv
// Purpose: indicator, boot select, key interrupt and gpio port
// Assumes: pins are asynchronous and pass two flip-flops
// Notes: avalon-mm slave answers every access in the cycle after its first cycle with clk_en high
`include "pin_io_regs.svh"
`default_nettype none
module pin_io
    import pin_io_pkg::*;
#(
    parameter int width = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // pins
    input wire logic boot_select_in,
    input wire logic key_n,
    output logic status_n,
    output logic done_n,
    output logic error_n,
    input wire logic [width-1:0] gpio_in,
    output logic [width-1:0] gpio_out,
    output logic [width-1:0] gpio_oe,
    // mode and interrupt
    output logic download_mode,
    output logic irq
);
    logic [1:0] rst_sync;
    logic rst_n;
    logic [width-1:0] gp_s1, gp_s2, gp_prev;
    logic boot_s1, boot_s2, key_s1, key_s2, key_prev;
    logic [31:0] ctrl;
    logic [width-1:0] out_val;
    logic [1:0] irq_stat, irq_en;
    logic ack;
    boot_type boot_state;
    ind_type ind;
    wire access = (read | write) & ~ack;
    wire wr = write & ack;
    wire lane0 = byteenable[0];
    wire build2 = ctrl[`CTRL_BUILD_BIT];
    wire [width-1:0] dir_mask = build2 ? width'(`FIXED_OUT_MASK) // RL10
        : {width{ctrl[`CTRL_DIR_BIT]}}; // RL5 RL6 RL7
    wire [width-1:0] data_in = ~gp_s2; // RL8
    wire key_event = ~key_s2 & key_prev; // RL4
    wire gpin_event = |((gp_prev & ~gp_s2) & ~dir_mask);
    wire clr_hit = wr & lane0 && address == `IRQ_CLR_OFS;
    wire [1:0] events = {gpin_event, key_event};
    wire [1:0] next_stat = events | (irq_stat & ~(clr_hit ?
        writedata[1:0] : 2'b00));
    assign rst_n = rst_sync[1];
    assign waitrequest = (read | write) & ~ack;
    assign ind = ctrl[`CTRL_IND_LO+:3];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) rst_sync <= 2'b00;
        else rst_sync <= {rst_sync[0], 1'b1};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {gp_s1, gp_s2, gp_prev} <= '1;
            {key_s1, key_s2, key_prev} <= 3'b111;
        end else if (clk_en) begin
            gp_s1 <= gpio_in;
            gp_s2 <= gp_s1;
            gp_prev <= gp_s2;
            key_s1 <= key_n;
            key_s2 <= key_s1;
            key_prev <= key_s2;
        end
    end

    // no reset: the strap must already be seen when the internal reset lifts
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            boot_s1 <= boot_select_in;
            boot_s2 <= boot_s1;
        end
    end

    // sampled once: a later change on the pin cannot upset running firmware
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) boot_state <= boot_wait_type;
        else if (clk_en && boot_state == boot_wait_type) // RL11
            boot_state <= boot_s2 ? boot_dl_type : boot_run_type; // RL2 RL3
    end
    assign download_mode = boot_state == boot_dl_type;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `CTRL_RESET;
            out_val <= '0;
            irq_en <= 2'b00;
            irq_stat <= 2'b00;
            ack <= 1'b0;
            readdata <= '0;
        end else if (clk_en) begin
            ack <= access;
            irq_stat <= next_stat;
            if (wr && lane0 && address == `CTRL_OFS) ctrl <= writedata;
            if (wr && lane0 && address == `GPIO_OUT_OFS)
                out_val <= writedata[width-1:0];
            if (wr && lane0 && address == `IRQ_EN_OFS)
                irq_en <= writedata[1:0];
            if (access && read) begin
                unique case (address)
                    `CTRL_OFS: readdata <= {25'h0, ctrl[6:4], 2'b00,
                        ctrl[1:0]};
                    `GPIO_OUT_OFS: readdata <= 32'(out_val);
                    `GPIO_IN_OFS: readdata <= 32'(data_in & ~dir_mask);
                    `STATUS_OFS: readdata <= {31'h0, download_mode};
                    `IRQ_STAT_OFS: readdata <= {30'h0, irq_stat};
                    `IRQ_EN_OFS: readdata <= {30'h0, irq_en};
                    default: readdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_out <= '1;
            gpio_oe <= '0;
            {status_n, done_n, error_n} <= 3'b111;
            irq <= 1'b0;
        end else if (clk_en) begin
            gpio_out <= ~out_val | ~dir_mask; // RL9
            gpio_oe <= dir_mask;
            status_n <= ~ind.status; // RL1
            done_n <= ~ind.done;
            error_n <= ~ind.error;
            irq <= |(next_stat & irq_en);
        end
    end

    rl1_ind_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> status_n == ~$past(ind.status)) // RL1
        else $error("status indicator not active low");

    done_ind_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> done_n == ~$past(ind.done)) // RL1
        else $error("done indicator not active low");

    err_ind_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> error_n == ~$past(ind.error)) // RL1
        else $error("error indicator not active low");

    rl10_fix_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && build2 |=> gpio_oe == `FIXED_OUT_MASK) // RL10
        else $error("fixed direction wrong");

    low_nib_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && build2 |=> gpio_out[3:0] == 4'hf) // RL10
        else $error("fixed input nibble driven");

    rl7_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && !build2 && ctrl[0] |=> &gpio_oe) // RL7
        else $error("not all pins output");

    rl6_in_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && !build2 && !ctrl[0] |=> gpio_oe == '0) // RL6 RL5
        else $error("not all pins input");

    rl9_drv_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && dir_mask[7] && out_val[7] |=> !gpio_out[7]) // RL9
        else $error("output not active low");

    idle_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> &(gpio_out | gpio_oe)) // RL9
        else $error("undriven pin not held high");

    rl4_key_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && key_event |=> irq_stat[0]) // RL4
        else $error("key event lost");

    set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && key_event && clr_hit |=> irq_stat[0]) // RL4
        else $error("clear beat a key event");

    key_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && clr_hit && writedata[0] && !key_event
        |=> !irq_stat[0]) // RL4
        else $error("key status not cleared");

    key_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && irq_stat[0] && !clr_hit |=> irq_stat[0]) // RL4
        else $error("key status not sticky");

    key_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && !key_event && !irq_stat[0] |=> !irq_stat[0]) // RL4
        else $error("key status set with no event");

    gpin_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && gpin_event |=> irq_stat[1]) // RL8
        else $error("input edge lost");

    irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && |(irq_stat & irq_en) && !clr_hit |=> irq) // RL4
        else $error("interrupt not raised");

    rl11_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        boot_state != boot_wait_type |=> $stable(boot_state)) // RL11
        else $error("boot mode changed");

    rl2_dl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && boot_state == boot_wait_type && boot_s2
        |=> download_mode) // RL2
        else $error("download mode not entered");

    rl3_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && boot_state == boot_wait_type && !boot_s2
        |=> boot_state == boot_run_type) // RL3
        else $error("run mode not entered");

    status_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && read && !ack && address == `STATUS_OFS
        |=> readdata[0] == $past(download_mode)) // RL2
        else $error("mode read back wrong");

    rl8_in_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        read && !ack && address == `GPIO_IN_OFS && clk_en && !dir_mask[0]
        && !gp_s2[0] |=> readdata[0]) // RL8
        else $error("low input not read as set");

    out_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        read && !ack && address == `GPIO_IN_OFS && clk_en && dir_mask[7]
        |=> !readdata[7]) // RL7
        else $error("output pin read as input");

    wait_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (read || write) && !ack |-> waitrequest)
        else $error("first cycle not stalled");

    wait_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && access |=> !waitrequest)
        else $error("access not answered");

    ack_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && ack |=> !ack)
        else $error("answer held too long");

    ctrl_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && wr && lane0 && address == `CTRL_OFS
        |=> ctrl == $past(writedata)) // RL5
        else $error("control write lost");

    out_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && wr && lane0 && address == `GPIO_OUT_OFS
        |=> out_val == $past(writedata[width-1:0])) // RL9
        else $error("output data write lost");

    en_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && wr && lane0 && address == `IRQ_EN_OFS
        |=> irq_en == $past(writedata[1:0])) // RL4
        else $error("enable write lost");

    lane_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && wr && !lane0 |=> $stable(ctrl))
        else $error("write without lane 0 took effect");

    unmapped_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && read && !ack && address == 5'h1c |=> readdata == '0)
        else $error("unmapped read not zero");

    key_irq_c: cover property (@(posedge ref_clk) key_event ##[1:3] irq);
    dl_c: cover property (@(posedge ref_clk) download_mode);
    build2_c: cover property (@(posedge ref_clk) build2 && gpin_event);
    clr_c: cover property (@(posedge ref_clk) clr_hit && irq_stat[0]);
    all_out_c: cover property (@(posedge ref_clk) !build2 && &gpio_oe);
endmodule
`default_nettype wire

// ===== verification/pin_board.sv
// Purpose: board side model of leds, switches, key and boot strap
// Assumes: gpio pins carry pull-ups when nobody drives them
// Notes: pin level is resolved from the design's enables
`default_nettype none
module pin_board (
    // from the design
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    // board controls
    input wire logic [7:0] sw_press,
    input wire logic key_press,
    input wire logic boot_hi,
    // to the design
    output logic [7:0] gpio_in,
    output logic key_n,
    output logic boot_select_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // a pressed switch pulls an undriven pin low
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ~sw_press);
    assign key_n = ~key_press;
    assign boot_select_in = boot_hi;
endmodule
`default_nettype wire

// ===== verification/pin_io_test.sv
// Purpose: register level tests of the pin io block
// Assumes: no fixed latency; the master waits for waitrequest low
// Notes: readdata is taken at the edge where waitrequest is seen low
`default_nettype none
module pin_io_test;
    import pin_io_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0, write = 1'b0;
    logic [31:0] writedata = 32'h0, readdata, d;
    logic [3:0] byteenable = 4'hf;
    logic waitrequest, boot_select_in, key_n, status_n, done_n, error_n;
    logic [7:0] gpio_in, gpio_out, gpio_oe, sw_press = 8'h00;
    logic download_mode, irq, key_press = 1'b0, boot_hi = 1'b1;
    int err_total = 0, n_tests = 0;
    pin_io u_pin_io (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .boot_select_in(boot_select_in), .key_n(key_n),
        .status_n(status_n), .done_n(done_n), .error_n(error_n),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .download_mode(download_mode), .irq(irq));
    pin_board u_pin_board (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .sw_press(sw_press), .key_press(key_press), .boot_hi(boot_hi),
        .gpio_in(gpio_in), .key_n(key_n), .boot_select_in(boot_select_in));
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // waits for the answer, sampled right at each rising edge, bounded by a count of 50
    task automatic acc(input logic [4:0] a, input logic w,
            input logic [31:0] v);
        int n;
        n = 0;
        address <= a;
        writedata <= v;
        if (w) write <= 1'b1;
        else read <= 1'b1;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 50) err_total++;
        d = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        acc(a, 1'b1, v);
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] e);
        acc(a, 1'b0, 32'h0);
        chk(d, e);
    endtask
    // boot level is set with reset so it is stable before release
    task automatic rst(input logic b);
        boot_hi <= b;
        rstn <= 1'b0;
        tick(3);
        rstn <= 1'b1;
        tick(6);
    endtask
    task automatic endt(input int t);
        $display("test %0d ends", t);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        report_and_stop;
    end
    initial begin
        rst(1'b1);
        chk(download_mode, 32'h1);
        rc(5'h0c, 32'h1);
        boot_hi <= 1'b0;
        tick(4);
        chk(download_mode, 32'h1);
        chk({status_n, done_n, error_n}, 32'h7);
        endt(1);
        rst(1'b0);
        chk(download_mode, 32'h0);
        wr(5'h00, 32'h51);
        tick(2);
        chk({status_n, done_n, error_n}, 32'h2);
        chk(gpio_oe, 32'hff);
        wr(5'h04, 32'h5a);
        tick(2);
        chk(gpio_out, 32'ha5);
        rc(5'h08, 32'h0);
        endt(2);
        wr(5'h00, 32'h0);
        sw_press <= 8'h81;
        tick(4);
        chk(gpio_oe, 32'h0);
        rc(5'h08, 32'h81);
        endt(3);
        wr(5'h00, 32'h2);
        wr(5'h04, 32'h30);
        sw_press <= 8'h05;
        tick(4);
        chk(gpio_oe, 32'hf0);
        chk(gpio_out, 32'hcf);
        rc(5'h08, 32'h05);
        wr(5'h00, 32'h3);
        tick(2);
        chk(gpio_oe, 32'hf0);
        endt(4);
        wr(5'h18, 32'h0);
        wr(5'h14, 32'h3);
        key_press <= 1'b1;
        tick(8);
        chk(irq, 32'h0);
        acc(5'h10, 1'b0, 32'h0);
        chk(d[0], 32'h1);
        wr(5'h18, 32'h1);
        tick(3);
        chk(irq, 32'h1);
        key_press <= 1'b0;
        tick(4);
        wr(5'h14, 32'h1);
        tick(3);
        chk(irq, 32'h0);
        endt(5);
        rc(5'h1c, 32'h0);
        endt(6);
        report_and_stop;
    end
endmodule
`default_nettype wire
